// *** logic/hacst_defines.svh ***
// Constants for the Hall angle and current sample timing block.
`ifndef HACST_DEFINES_SVH
`define HACST_DEFINES_SVH
`define HACST_CLK_MHZ 25
`define HACST_SAMPLE_DELAY_NS 6000
`define HACST_SAMPLE_DELAY_CYC ((`HACST_SAMPLE_DELAY_NS * `HACST_CLK_MHZ + 999) / 1000)
`define HACST_PWM_FREQ_HZ 10000
`define HACST_PWM_PERIOD_US (1000000 / `HACST_PWM_FREQ_HZ)
`define HACST_PWM_PERIOD_CYC (`HACST_PWM_PERIOD_US * `HACST_CLK_MHZ)
`define HACST_SECTOR_DEG 60
`define HACST_SPEED_TAPS 6
`define HACST_ADC_BITS 12
`define HACST_BIPOLAR_STEP_UV10 3125
`define HACST_DIRECT_STEP_UV10 6250
`define HACST_SCALE_MV_PER_A 200
`define HACST_ANGLE_FRAC 16
`define HACST_ANGLE_W 25
`define HACST_SPEED_SHIFT 8
`endif

// *** logic/hacst_pkg.sv ***
// Types for the Hall angle and current sample timing block.
package hacst_pkg;
  typedef logic [2:0] hacst_hall_t;
  typedef logic signed [15:0] hacst_current_t;
  typedef enum logic {HACST_DIRECT, HACST_BIPOLAR} hacst_chan_e;
endpackage

// *** logic/hacst_speed_avg.sv ***
// Six-tap moving average of instantaneous speed values.
`timescale 1ns/1ns
`include "hacst_defines.svh"
module hacst_speed_avg #(
  parameter int W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic valid_i,
  input wire logic [W-1:0] speed_i,
  output logic [W-1:0] avg_o
);
  initial begin
    if (W < 2 || W > 32) $error("speed width unsupported");
  end
  logic [W-1:0] hist_q [`HACST_SPEED_TAPS];
  logic [W-1:0] hist_d [`HACST_SPEED_TAPS];
  logic [W+2:0] sum_q, sum_d;
  logic [W-1:0] avg_q, avg_d;
  always_comb begin
    hist_d = hist_q;
    sum_d = sum_q;
    avg_d = avg_q;
    if (valid_i) begin
      for (int i = `HACST_SPEED_TAPS - 1; i > 0; i--) begin
        hist_d[i] = hist_q[i-1];
      end
      hist_d[0] = speed_i;
      // Running sum avoids an adder tree: add newest, drop oldest.
      sum_d = sum_q + (W+3)'(speed_i) - (W+3)'(hist_q[`HACST_SPEED_TAPS-1]);
      avg_d = W'(sum_d / (W+3)'(`HACST_SPEED_TAPS));
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < `HACST_SPEED_TAPS; i++) begin
        hist_q[i] <= '0;
      end
      sum_q <= '0;
      avg_q <= '0;
    end else begin
      hist_q <= hist_d;
      sum_q <= sum_d;
      avg_q <= avg_d;
    end
  end
  assign avg_o = avg_q;
  avg_zero_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    !valid_i && $stable(sum_q) |=> $stable(avg_q)) else $error("average moved without input");
endmodule

// *** logic/hacst_top.sv ***
// Hall angle estimator, speed measure and current sample timing.
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "hacst_defines.svh"
module hacst_top #(
  parameter int SPEED_W = 16,
  parameter int PWM_PERIOD_CYC = `HACST_PWM_PERIOD_CYC,
  parameter int SAMPLE_DELAY_CYC = `HACST_SAMPLE_DELAY_CYC,
  parameter int TIMER_W = 24
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire hacst_pkg::hacst_hall_t HALL_I,
  input wire logic PWM_TICK_I,
  input wire logic [2:0] LOW_SIDE_ON_I,
  input wire logic ADC_VALID_I,
  input wire logic [1:0] ADC_PHASE_I,
  input wire hacst_pkg::hacst_chan_e ADC_CHAN_I,
  input wire logic [11:0] ADC_CODE_I,
  input wire logic [11:0] ZERO_OFFSET_CODE_I,
  output logic SAMPLE_TRIG_O,
  output logic SAMPLE_MISSED_O,
  output logic [1:0] SAMPLE_PHASE_O,
  output logic [8:0] ANGLE_DEG_O,
  output logic HALL_CHANGE_O,
  output logic [SPEED_W-1:0] SPEED_INST_O,
  output logic [SPEED_W-1:0] SPEED_AVG_O,
  output hacst_pkg::hacst_current_t PHASE_A_CURRENT_O,
  output hacst_pkg::hacst_current_t PHASE_B_CURRENT_O,
  output logic CURRENT_VALID_O
);
  import hacst_pkg::*;
  initial begin
    if (SAMPLE_DELAY_CYC < 1 || SAMPLE_DELAY_CYC >= PWM_PERIOD_CYC) $error("bad sample delay");
    if (TIMER_W < 16 || TIMER_W > 30) $error("bad timer width");
  end
  localparam int AW = `HACST_ANGLE_W;
  localparam int FR = `HACST_ANGLE_FRAC;
  localparam logic [AW-1:0] SECTOR_FX = AW'(`HACST_SECTOR_DEG) << FR;
  localparam logic [AW-1:0] REV_FX = AW'(360) << FR;
  localparam logic [TIMER_W-1:0] SPD_NUM = TIMER_W'(1) << (TIMER_W - 1);

  // Fixed Hall state to sector angle table, in whole degrees.
  function automatic logic [8:0] hall_angle(input hacst_hall_t h);
    case (h)
      3'h1: hall_angle = 9'd0;
      3'h3: hall_angle = 9'd60;
      3'h2: hall_angle = 9'd120;
      3'h6: hall_angle = 9'd180;
      3'h4: hall_angle = 9'd240;
      3'h5: hall_angle = 9'd300;
      default: hall_angle = 9'd0;
    endcase
  endfunction

  // Reciprocal of the coarse Hall interval; saturates when the output is too narrow.
  function automatic logic [SPEED_W-1:0] speed_of(input logic [TIMER_W-1:0] t);
    logic [TIMER_W-1:0] per;
    logic [TIMER_W-1:0] q;
    per = t >> `HACST_SPEED_SHIFT;
    if (per == '0) begin
      per = TIMER_W'(1);
    end
    q = SPD_NUM / per;
    if (TIMER_W > SPEED_W && (q >> SPEED_W) != '0) begin
      speed_of = '1;
    end else begin
      speed_of = SPEED_W'(q);
    end
  endfunction

  // Converts a code to a signed current in milliamps.
  function automatic hacst_current_t to_current(input hacst_chan_e ch, input logic [11:0] code,
      input logic [11:0] zero);
    logic signed [31:0] diff_uv;
    diff_uv = 32'sd0;
    if (ch == HACST_BIPOLAR) begin
      diff_uv = (32'($signed({1'b0, code})) - 32'sd2048 - 32'($signed({1'b0, zero})) + 32'sd2048)
        * 32'sd`HACST_BIPOLAR_STEP_UV10 / 32'sd10;
    end else begin
      diff_uv = (32'($signed({1'b0, code})) - 32'($signed({1'b0, zero})))
        * 32'sd`HACST_DIRECT_STEP_UV10 / 32'sd10;
    end
    to_current = 16'(diff_uv / 32'sd`HACST_SCALE_MV_PER_A);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Sampling trigger.
  typedef enum logic [1:0] {HACST_WAIT_ON, HACST_DELAY, HACST_DONE} hacst_trig_e;
  hacst_trig_e trig_q, trig_d;
  logic [15:0] dly_q, dly_d;
  logic trig_out_q, trig_out_d, miss_q, miss_d;
  logic [1:0] phase_q, phase_d;
  wire all_low = &LOW_SIDE_ON_I;
  always_comb begin
    trig_d = trig_q;
    dly_d = dly_q;
    trig_out_d = 1'b0;
    miss_d = 1'b0;
    phase_d = phase_q;
    case (trig_q)
      HACST_WAIT_ON: begin
        dly_d = '0;
        if (all_low) begin
          trig_d = HACST_DELAY;
        end
      end
      HACST_DELAY: begin
        if (!all_low) begin
          // Low-side window closed early: the period yields no sample.
          miss_d = 1'b1;
          trig_d = HACST_DONE;
        end else if (dly_q == 16'(SAMPLE_DELAY_CYC - 1)) begin
          trig_out_d = 1'b1;
          phase_d = 2'h0;
          trig_d = HACST_DONE;
        end else begin
          dly_d = dly_q + 16'h0001;
        end
      end
      HACST_DONE: begin
        if (!all_low) begin
          trig_d = HACST_WAIT_ON;
        end
      end
      default: trig_d = HACST_WAIT_ON;
    endcase
    if (PWM_TICK_I) begin
      trig_d = all_low ? HACST_DELAY : HACST_WAIT_ON;
      dly_d = '0;
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trig_q <= HACST_WAIT_ON;
      dly_q <= '0;
      trig_out_q <= 1'b0;
      miss_q <= 1'b0;
      phase_q <= 2'h0;
    end else begin
      trig_q <= trig_d;
      dly_q <= dly_d;
      trig_out_q <= trig_out_d;
      miss_q <= miss_d;
      phase_q <= phase_d;
    end
  end
  assign SAMPLE_TRIG_O = trig_out_q;
  assign SAMPLE_MISSED_O = miss_q;
  assign SAMPLE_PHASE_O = phase_q;

  trig_needs_low_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    trig_out_d |-> all_low) else $error("trigger outside low-side window");
  trig_delay_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    $rose(trig_out_q) |-> $past(trig_q == HACST_DELAY) && $past(dly_q) == 16'(SAMPLE_DELAY_CYC - 1))
    else $error("trigger delay wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Current conversion.
  hacst_current_t cur_a_q, cur_a_d, cur_b_q, cur_b_d;
  logic cur_v_q, cur_v_d;
  always_comb begin
    cur_a_d = cur_a_q;
    cur_b_d = cur_b_q;
    cur_v_d = 1'b0;
    if (ADC_VALID_I) begin
      if (ADC_PHASE_I == 2'h0) begin
        cur_a_d = to_current(ADC_CHAN_I, ADC_CODE_I, ZERO_OFFSET_CODE_I);
      end else if (ADC_PHASE_I == 2'h1) begin
        cur_b_d = to_current(ADC_CHAN_I, ADC_CODE_I, ZERO_OFFSET_CODE_I);
        cur_v_d = 1'b1;
      end
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cur_a_q <= '0;
      cur_b_q <= '0;
      cur_v_q <= 1'b0;
    end else begin
      cur_a_q <= cur_a_d;
      cur_b_q <= cur_b_d;
      cur_v_q <= cur_v_d;
    end
  end
  assign PHASE_A_CURRENT_O = cur_a_q;
  assign PHASE_B_CURRENT_O = cur_b_q;
  assign CURRENT_VALID_O = cur_v_q;

  cur_b_valid_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    ADC_VALID_I && ADC_PHASE_I == 2'h1 |=> cur_v_q) else $error("phase B result not flagged");

  //////////////////////////////////////////////////////////////////////////////
  // Hall angle interpolation and speed timing.
  hacst_hall_t hall_q, hall_d;
  logic [15:0] pwm_cnt_q, pwm_cnt_d, last_cnt_q, last_cnt_d;
  logic [AW-1:0] base_q, base_d, off_q, off_d, step_q, step_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [SPEED_W-1:0] spd_q, spd_d;
  logic chg_q, chg_d, seen_q, seen_d;
  wire hall_edge = HALL_I != hall_q;
  always_comb begin
    hall_d = HALL_I;
    pwm_cnt_d = pwm_cnt_q;
    last_cnt_d = last_cnt_q;
    base_d = base_q;
    off_d = off_q;
    step_d = step_q;
    tmr_d = (tmr_q == '1) ? tmr_q : tmr_q + 1'b1;
    spd_d = spd_q;
    chg_d = 1'b0;
    seen_d = seen_q;
    if (hall_edge) begin
      chg_d = seen_q;
      seen_d = 1'b1;
      base_d = AW'(hall_angle(HALL_I)) << FR;
      off_d = '0;
      last_cnt_d = pwm_cnt_q;
      pwm_cnt_d = '0;
      // Sector spans last_cnt ticks, so each tick adds 60 deg over that count.
      step_d = (pwm_cnt_q == '0) ? '0 : AW'(SECTOR_FX / AW'(pwm_cnt_q));
      // Speed is the reciprocal of the Hall interval in units of 256 clock cycles.
      spd_d = speed_of(tmr_q);
      tmr_d = '0;
    end else if (PWM_TICK_I && seen_q) begin
      pwm_cnt_d = (pwm_cnt_q == '1) ? pwm_cnt_q : pwm_cnt_q + 16'h0001;
      off_d = (off_q + step_q > SECTOR_FX) ? SECTOR_FX : off_q + step_q;
    end
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hall_q <= '0;
      pwm_cnt_q <= '0;
      last_cnt_q <= '0;
      base_q <= '0;
      off_q <= '0;
      step_q <= '0;
      tmr_q <= '0;
      spd_q <= '0;
      chg_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      hall_q <= hall_d;
      pwm_cnt_q <= pwm_cnt_d;
      last_cnt_q <= last_cnt_d;
      base_q <= base_d;
      off_q <= off_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      spd_q <= spd_d;
      chg_q <= chg_d;
      seen_q <= seen_d;
    end
  end
  logic [AW-1:0] ang_sum;
  always_comb begin
    ang_sum = base_q + off_q;
    if (ang_sum >= REV_FX) begin
      ang_sum = ang_sum - REV_FX;
    end
  end
  assign ANGLE_DEG_O = 9'(ang_sum >> FR);
  assign HALL_CHANGE_O = chg_q;
  assign SPEED_INST_O = spd_q;

  hacst_speed_avg #(
    .W(SPEED_W)
  ) u_avg (
    .CORE_CLK_I(CORE_CLK_I),
    .RESET_N_I(RESET_N_I),
    .valid_i(chg_q),
    .speed_i(spd_q),
    .avg_o(SPEED_AVG_O)
  );

  angle_load_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    hall_edge |=> base_q == (AW'(hall_angle($past(HALL_I))) << FR) && off_q == '0)
    else $error("Hall angle not loaded");
  angle_cap_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    off_q <= SECTOR_FX) else $error("angle ran past sector");
  count_capture_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    hall_edge |=> last_cnt_q == $past(pwm_cnt_q) && pwm_cnt_q == '0)
    else $error("PWM count not captured");
  advance_tick_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    !hall_edge && !PWM_TICK_I |=> $stable(off_q)) else $error("angle moved without tick");
endmodule

// *** test/hacst_pwm_model.sv ***
// Model of the PWM generator that paces the angle and trigger logic.
`timescale 1ns/1ns
module hacst_pwm_model #(
  parameter int PERIOD = 100
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] on_len_i,
  output logic tick_o,
  output logic [2:0] low_on_o
);
  int cnt_q;
  int cnt_d;
  always_comb begin
    cnt_d = (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
  end
  // All low sides conduct together from the period start for on_len cycles.
  // Raising them with the tick exercises both arming paths at once.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
      tick_o <= 1'b0;
      low_on_o <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= (cnt_d == 0);
      low_on_o <= {3{cnt_d < int'(on_len_i)}};
    end
  end
endmodule

// *** test/test_hacst_top.sv ***
// Self-checking bench for the Hall angle and current sample timing block.
`timescale 1ns/1ns
module test_hacst_top;
  import hacst_pkg::*;
  localparam int P = 100;
  localparam int D = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] on_len = 8'd50;
  hacst_hall_t hall = 3'h0;
  logic tick;
  logic [2:0] low;
  logic av = 1'b0;
  logic [1:0] aph = 2'h0;
  hacst_chan_e ach = HACST_DIRECT;
  logic [11:0] acode = 12'h000;
  logic [11:0] azero = 12'h000;
  logic trig;
  logic miss;
  logic chg;
  logic cval;
  logic [1:0] sph;
  logic [8:0] ang;
  logic [31:0] sinst;
  logic [31:0] savg;
  hacst_current_t ia;
  hacst_current_t ib;
  int err_count = 0;
  int checks_done = 0;
  int hst[6] = '{1, 3, 2, 6, 4, 5};
  int ei[8] = '{0, 8388608, 0, 0, 0, 0, 8388608, 2796202};
  int ea[8] = '{0, 1398101, 0, 0, 0, 0, 8388608, 7456540};
  always #20 clk = ~clk;
  hacst_pwm_model #(.PERIOD(P)) pwm_u (.clk_i(clk), .rst_n_i(rst_n), .on_len_i(on_len),
    .tick_o(tick), .low_on_o(low));
  hacst_top #(.SPEED_W(32), .PWM_PERIOD_CYC(P), .SAMPLE_DELAY_CYC(D)) dut_u (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .HALL_I(hall), .PWM_TICK_I(tick),
    .LOW_SIDE_ON_I(low), .ADC_VALID_I(av), .ADC_PHASE_I(aph), .ADC_CHAN_I(ach),
    .ADC_CODE_I(acode), .ZERO_OFFSET_CODE_I(azero), .SAMPLE_TRIG_O(trig),
    .SAMPLE_MISSED_O(miss), .SAMPLE_PHASE_O(sph), .ANGLE_DEG_O(ang), .HALL_CHANGE_O(chg),
    .SPEED_INST_O(sinst), .SPEED_AVG_O(savg), .PHASE_A_CURRENT_O(ia),
    .PHASE_B_CURRENT_O(ib), .CURRENT_VALID_O(cval));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_tick();
    do @(posedge clk); while (tick !== 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_trig();
    int k;
    int m;
    wait_tick();
    k = 0;
    m = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
      m += int'(miss === 1'b1);
    end while (trig !== 1'b1 && k < P);
    // Counted from the edge at which the design first samples the tick.
    chk_num(k, D, "trigger delay");
    chk_num(m, 0, "missed in long window");
    chk_num(32'(sph), 0, "sample phase");
  endtask
  // A window shorter than the delay must end in a miss, never a trigger.
  task automatic test_short();
    int t;
    int m;
    @(posedge clk);
    on_len <= 8'd5;
    wait_tick();
    t = 0;
    m = 0;
    repeat (P - 5) begin
      @(posedge clk);
      t += int'(trig === 1'b1);
      m += int'(miss === 1'b1);
    end
    chk_num(t, 0, "trigger in short window");
    chk_num(m, 1, "miss pulses");
    on_len <= 8'd50;
  endtask
  task automatic adc_pair(input hacst_chan_e ca, input int cda, input int za,
      input hacst_chan_e cb, input int cdb, input int zb, input int xa, input int xb);
    @(posedge clk);
    av <= 1'b1;
    aph <= 2'h0;
    ach <= ca;
    acode <= 12'(cda);
    azero <= 12'(za);
    @(posedge clk);
    aph <= 2'h1;
    ach <= cb;
    acode <= 12'(cdb);
    azero <= 12'(zb);
    @(posedge clk);
    av <= 1'b0;
    #1;
    chk_num(32'(ia), 32'(xa), "phase a current");
    chk_num(32'(ib), 32'(xb), "phase b current");
    chk_num(32'(cval), 1, "current valid");
  endtask
  // One Hall interval: the new state is already driven at entry.
  task automatic hall_int(input int i, input int ticks, input int prev);
    int base;
    int seen;
    base = (i % 6) * 60;
    seen = 0;
    for (int c = 0; c < ticks * P; c++) begin
      @(posedge clk);
      if (c < 5) seen += int'(chg === 1'b1);
      if (c == 5) chk_num(32'(ang), base, "hall angle");
      if (c == 5) chk_num(seen, int'(i > 0), "hall change pulse");
      if (c == 8 && ei[i] != 0) chk_num(sinst, ei[i], "inst speed");
      if (c == 8 && ea[i] != 0) chk_num(savg, ea[i], "avg speed");
      if (c == 250 && i > 0) chk_num(32'(ang), base + 120 / prev, "step");
      if (c == 650 || c == 750) chk_num(32'(ang), (base + 60) % 360, "cap");
    end
    hall <= hacst_hall_t'(hst[(i + 1) % 6]);
  endtask
  task automatic test_hall();
    wait_tick();
    repeat (10) @(posedge clk);
    hall <= hacst_hall_t'(hst[0]);
    for (int i = 0; i < 8; i++) begin
      hall_int(i, (i == 6) ? 8 : 4, (i == 7) ? 8 : 4);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_num(32'(ang), 0, "angle after reset");
    chk_num(savg, 0, "avg after reset");
    test_trig();
    test_short();
    test_trig();
    adc_pair(HACST_DIRECT, 1000, 600, HACST_BIPOLAR, 664, 600, 1250, 100);
    adc_pair(HACST_BIPOLAR, 536, 600, HACST_DIRECT, 600, 760, -100, -500);
    test_hall();
    end_sim();
  end
  // The whole sequence needs some four thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
